//--- src/heatseal_pkg.sv
// Package with register map, parameter layout and timing constants.
package heatseal_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_RANGE = 8'h00;
    localparam logic [7:0] ADDR_OK_LOW = 8'h04;
    localparam logic [7:0] ADDR_OK_HIGH = 8'h08;
    localparam logic [7:0] ADDR_CAL_TEMP = 8'h0c;
    localparam logic [7:0] ADDR_HEAT_LIM = 8'h10;
    localparam logic [7:0] ADDR_DIAG_EN = 8'h14;
    localparam logic [7:0] ADDR_IMP_LEN = 8'h18;
    localparam logic [7:0] ADDR_FORMAT = 8'h1c;
    localparam logic [7:0] ADDR_STATE = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    // Range/alloy codes and the fixed selection that RANGE_FIXED maps to.
    localparam logic [7:0] RANGE_FIXED = 8'h00;
    localparam logic [7:0] RANGE_SWITCH = 8'h0a;
    localparam logic [3:0] FIXED_RANGE_SEL = 4'h0;
    localparam logic [3:0] FIXED_COEF_SEL = 4'h0;
    // Parameter limits.
    localparam logic [7:0] OK_MIN = 8'h03;
    localparam logic [7:0] OK_MAX = 8'h63;
    localparam logic [7:0] CAL_MAX = 8'h28;
    localparam logic [7:0] HEAT_LIM_MAX = 8'h32;
    localparam logic [7:0] IMP_MIN = 8'h11;
    localparam logic [7:0] IMP_MAX = 8'h1e;
    // Interrupt bit positions.
    localparam int IRQ_CUTOFF = 0;
    localparam int IRQ_RANGE = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W = 3;
    // Timing in the printed units and the derived cycle counts.
    localparam int CLK_HZ = 25000000;
    localparam int HEAT_UNIT_MS = 100;
    localparam int HEAT_UNIT_CYC = CLK_HZ / 1000 * HEAT_UNIT_MS;
    localparam int IMP_UNIT_US = 100;
    localparam int IMP_UNIT_CYC = CLK_HZ / 1000000 * IMP_UNIT_US;
    localparam int FAST_HZ = 4;
    localparam int SLOW_HZ = 1;
    localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
    localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
    // Actual-value scaling: full scale code at the top temperature.
    localparam logic [8:0] TEMP_FULL = 9'h12c;
    localparam logic [11:0] DAC_FULL = 12'h0fff;
    localparam logic [8:0] ALARM_STEP = 9'h014;
    // Indicator modes.
    typedef enum logic [1:0] {
        LED_OFF = 2'b00, LED_ON = 2'b01, LED_FAST = 2'b10, LED_SLOW = 2'b11
    } led_mode_type;
    // Configuration set by the fieldbus master.
    typedef struct packed {
        logic [7:0] range_alloy;
        logic [7:0] ok_low;
        logic [7:0] ok_high;
        logic [7:0] cal_temp;
        logic [7:0] heat_lim;
        logic diag_en;
        logic [7:0] imp_len;
        logic swap_bytes;
    } cfg_type;
    localparam cfg_type CFG_RESET = '{8'h0a, 8'h0a, 8'h0a, 8'h14, 8'h00, 1'b1, 8'h11, 1'b0};
endpackage : heatseal_pkg

//--- src/heatseal_param_supervisor.sv
// Parameter interpretation and supervision logic with an APB register file.
`timescale 1ns/1ps
`default_nettype none
module heatseal_param_supervisor
    import heatseal_pkg::*;
#(
    parameter int HEAT_UNIT = HEAT_UNIT_CYC,
    parameter int FAST_HALF = FAST_HALF_CYC,
    parameter int SLOW_HALF = SLOW_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_req_pin,
    input wire logic [3:0] rotary_range_pin,
    input wire logic [3:0] rotary_coef_pin,
    input wire logic [8:0] meas_temp,
    input wire logic [8:0] set_point,
    input wire logic [3:0] fault_code,
    input wire logic meas_trigger,
    input wire logic [15:0] rx_word,
    output logic heat_enable,
    output logic [3:0] range_sel,
    output logic [3:0] element_temp_coefficient,
    output logic [7:0] cal_temp_out,
    output logic temp_ok,
    output logic meas_impulse,
    output logic [11:0] actual_dac,
    output logic alarm_led,
    output logic diag_valid,
    output logic [3:0] diag_code,
    output logic [15:0] tx_word,
    output logic [15:0] rx_word_ordered,
    output logic irq
);
    // Indicator mode for a fault code.
    function automatic led_mode_type led_mode(input logic [3:0] code);
        if (code == 4'h0) begin
            led_mode = LED_OFF;
        end else if (code <= 4'h7) begin
            led_mode = LED_ON;
        end else if (code <= 4'h9) begin
            led_mode = LED_FAST;
        end else begin
            led_mode = LED_SLOW;
        end
    endfunction : led_mode

    // Swaps the two bytes of a word when asked to.
    function automatic logic [15:0] order(input logic [15:0] w, input logic sw);
        order = sw ? {w[7:0], w[15:8]} : w;
    endfunction : order

    // Linear temperature to output code, clamped at full scale.
    function automatic logic [11:0] to_dac(input logic [8:0] t);
        logic [20:0] p;
        p = 21'h0_0000;
        p = {12'h000, (t > TEMP_FULL) ? TEMP_FULL : t} * {9'h000, DAC_FULL};
        to_dac = 12'(p / {12'h000, TEMP_FULL});
    endfunction : to_dac

    cfg_type cfg_r; // Configuration registers.
    logic [IRQ_W-1:0] irq_stat_r; // Sticky interrupt status.
    logic [IRQ_W-1:0] irq_mask_r; // Interrupt mask.
    logic [1:0] start_sync_r; // Start request synchroniser.
    logic [3:0] rng_s1_r, rng_s2_r; // Range switch synchroniser.
    logic [3:0] coef_s1_r, coef_s2_r; // Coefficient switch synchroniser.
    logic lock_r; // Set after a cut-off until start drops.
    logic [31:0] unit_cnt_r; // Cycles within one 100 ms unit.
    logic [7:0] heat_cnt_r; // Elapsed heating units.
    logic [16:0] imp_cnt_r; // Remaining impulse cycles.
    logic [31:0] fast_cnt_r, slow_cnt_r; // Blink dividers.
    logic fast_r, slow_r; // Blink phases.
    logic [3:0] fault_prev_r; // Fault code last cycle.

    // Bus decode.
    wire logic access = psel && penable && !pready;
    wire logic done = psel && penable && pready;
    wire logic wr = done && pwrite;
    wire logic rd = done && !pwrite;
    wire logic [7:0] wv = pwdata[7:0];
    wire logic sel_rng = paddr == ADDR_RANGE;
    wire logic sel_okl = paddr == ADDR_OK_LOW;
    wire logic sel_okh = paddr == ADDR_OK_HIGH;
    wire logic sel_cal = paddr == ADDR_CAL_TEMP;
    wire logic sel_lim = paddr == ADDR_HEAT_LIM;
    wire logic sel_dia = paddr == ADDR_DIAG_EN;
    wire logic sel_imp = paddr == ADDR_IMP_LEN;
    wire logic sel_fmt = paddr == ADDR_FORMAT;
    wire logic sel_st = paddr == ADDR_STATE;
    wire logic sel_is = paddr == ADDR_IRQ_STAT;
    wire logic sel_im = paddr == ADDR_IRQ_MASK;
    wire logic mapped = sel_rng | sel_okl | sel_okh | sel_cal | sel_lim | sel_dia |
                        sel_imp | sel_fmt | sel_st | sel_is | sel_im;
    // Values outside the documented ranges are refused.
    wire logic bad_val = (sel_rng && wv != RANGE_FIXED && wv != RANGE_SWITCH) ||
                         ((sel_okl || sel_okh) && (wv < OK_MIN || wv > OK_MAX)) ||
                         (sel_cal && wv > CAL_MAX) ||
                         (sel_lim && wv > HEAT_LIM_MAX) ||
                         (sel_imp && (wv < IMP_MIN || wv > IMP_MAX));
    wire logic err = !mapped || (pwrite && bad_val);
    wire logic wr_ok = wr && !pslverr;

    // Heating supervision signals.
    wire logic start_s = start_sync_r[1];
    wire logic unit_end = unit_cnt_r == 32'(HEAT_UNIT - 1);
    wire logic cut_now = heat_enable && cfg_r.heat_lim != 8'h00 &&
                         heat_cnt_r == cfg_r.heat_lim;
    wire logic heat_nxt = start_s && !lock_r && !cut_now;
    wire logic [16:0] imp_load = 17'(cfg_r.imp_len) * 17'(IMP_UNIT_CYC);

    // Window bounds and the derived outputs.
    wire logic [9:0] win_lo = {1'b0, set_point} - {2'b00, cfg_r.ok_low};
    wire logic [9:0] win_hi = {1'b0, set_point} + {2'b00, cfg_r.ok_high};
    wire logic ok_nxt = ({1'b0, meas_temp} >= win_lo || set_point < 9'(cfg_r.ok_low)) &&
                        {1'b0, meas_temp} <= win_hi;
    wire led_mode_type mode = led_mode(fault_code);
    wire logic led_nxt = (mode == LED_ON) || (mode == LED_FAST && fast_r) ||
                         (mode == LED_SLOW && slow_r);
    wire logic [8:0] alarm_temp = 9'(fault_code * ALARM_STEP);
    wire logic [11:0] alarm_dac = (fault_code >= 4'h8 && slow_r) ? DAC_FULL : to_dac(alarm_temp);
    wire logic [11:0] dac_nxt = (fault_code != 4'h0) ? alarm_dac : to_dac(meas_temp);
    wire logic [15:0] tx_val = (fault_code != 4'h0) ? {12'h000, fault_code} :
                               {7'h00, meas_temp};
    wire logic range_chg = wr_ok && sel_rng && wv != cfg_r.range_alloy;
    wire logic [IRQ_W-1:0] irq_set = {fault_code != 4'h0 && fault_prev_r == 4'h0,
                                      range_chg, cut_now};
    wire logic [31:0] state_word = {12'h000, fault_code, 13'h0000, temp_ok, lock_r, heat_enable};
    // A status read clears only the bits it returned, so an event that lands
    // between the data capture and the read's completion is not lost.
    wire logic [IRQ_W-1:0] irq_clr = (rd && sel_is) ? prdata[IRQ_W-1:0] : '0;
    wire logic [31:0] rd_mux =
        sel_rng ? {24'h00_0000, cfg_r.range_alloy} :
        sel_okl ? {24'h00_0000, cfg_r.ok_low} :
        sel_okh ? {24'h00_0000, cfg_r.ok_high} :
        sel_cal ? {24'h00_0000, cfg_r.cal_temp} :
        sel_lim ? {24'h00_0000, cfg_r.heat_lim} :
        sel_dia ? {31'h0000_0000, cfg_r.diag_en} :
        sel_imp ? {24'h00_0000, cfg_r.imp_len} :
        sel_fmt ? {31'h0000_0000, cfg_r.swap_bytes} :
        sel_st ? state_word :
        sel_is ? {29'h0000_0000, irq_stat_r} :
        sel_im ? {29'h0000_0000, irq_mask_r} : 32'h0000_0000;

    // Bus answer: one wait cycle, then data, ready and error together.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && err;
            prdata <= (access && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
        end
    end

    // Configuration writes; the calibration value touches nothing else.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RESET;
            irq_mask_r <= '0;
        end else if (wr_ok) begin
            if (sel_rng) cfg_r.range_alloy <= wv;
            if (sel_okl) cfg_r.ok_low <= wv;
            if (sel_okh) cfg_r.ok_high <= wv;
            if (sel_cal) cfg_r.cal_temp <= wv;
            if (sel_lim) cfg_r.heat_lim <= wv;
            if (sel_dia) cfg_r.diag_en <= pwdata[0];
            if (sel_imp) cfg_r.imp_len <= wv;
            if (sel_fmt) cfg_r.swap_bytes <= pwdata[0];
            if (sel_im) irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // Sticky status: a new event wins over the clearing read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
            fault_prev_r <= 4'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq <= |(irq_stat_r & irq_mask_r);
            fault_prev_r <= fault_code;
        end
    end

    // Pin synchronisers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_sync_r <= 2'b00;
            {rng_s1_r, rng_s2_r, coef_s1_r, coef_s2_r} <= 16'h0000;
        end else begin
            start_sync_r <= {start_sync_r[0], start_req_pin};
            {rng_s1_r, rng_s2_r} <= {rotary_range_pin, rng_s1_r};
            {coef_s1_r, coef_s2_r} <= {rotary_coef_pin, coef_s1_r};
        end
    end

    // Heating time limit: counts units while heating, locks after a cut.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heat_enable <= 1'b0;
            lock_r <= 1'b0;
            unit_cnt_r <= 32'h0000_0000;
            heat_cnt_r <= 8'h00;
        end else begin
            heat_enable <= heat_nxt;
            lock_r <= start_s && (lock_r || cut_now);
            unit_cnt_r <= (!heat_enable || unit_end) ? 32'h0000_0000 : unit_cnt_r + 32'h0000_0001;
            heat_cnt_r <= !heat_enable ? 8'h00 :
                          (unit_end && heat_cnt_r != 8'hff) ? heat_cnt_r + 8'h01 : heat_cnt_r;
        end
    end

    // Measuring impulse of the configured length per trigger.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imp_cnt_r <= 17'h0_0000;
            meas_impulse <= 1'b0;
        end else begin
            if (imp_cnt_r != 17'h0_0000) begin
                imp_cnt_r <= imp_cnt_r - 17'h0_0001;
            end else if (meas_trigger) begin
                imp_cnt_r <= imp_load;
            end
            meas_impulse <= (imp_cnt_r > 17'h0_0001) || (imp_cnt_r == 17'h0_0000 && meas_trigger);
        end
    end

    // Blink phase dividers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {fast_cnt_r, slow_cnt_r} <= 64'h0000_0000_0000_0000;
            {fast_r, slow_r} <= 2'b00;
        end else begin
            fast_cnt_r <= (fast_cnt_r == 32'(FAST_HALF - 1)) ? 32'h0000_0000 : fast_cnt_r + 32'h0000_0001;
            slow_cnt_r <= (slow_cnt_r == 32'(SLOW_HALF - 1)) ? 32'h0000_0000 : slow_cnt_r + 32'h0000_0001;
            if (fast_cnt_r == 32'(FAST_HALF - 1)) fast_r <= !fast_r;
            if (slow_cnt_r == 32'(SLOW_HALF - 1)) slow_r <= !slow_r;
        end
    end

    // Registered outputs derived from configuration and measurements.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {range_sel, element_temp_coefficient} <= 8'h00;
            {cal_temp_out, temp_ok, actual_dac, alarm_led} <= 22'h00_0000;
            {diag_valid, diag_code} <= 5'h00;
            {tx_word, rx_word_ordered} <= 32'h0000_0000;
        end else begin
            range_sel <= (cfg_r.range_alloy == RANGE_FIXED) ? FIXED_RANGE_SEL : rng_s2_r;
            element_temp_coefficient <= (cfg_r.range_alloy == RANGE_FIXED) ?
                                        FIXED_COEF_SEL : coef_s2_r;
            cal_temp_out <= cfg_r.cal_temp;
            temp_ok <= ok_nxt;
            actual_dac <= dac_nxt;
            alarm_led <= led_nxt;
            diag_valid <= cfg_r.diag_en && fault_code != 4'h0;
            diag_code <= fault_code;
            tx_word <= order(tx_val, cfg_r.swap_bytes);
            rx_word_ordered <= order(rx_word, cfg_r.swap_bytes);
        end
    end

    // Checks.
    cut_stops_heat_a: assert property (@(posedge pclk) disable iff (!presetn)
        cut_now |=> !heat_enable ##1 !heat_enable) else $error("heat not cut");
    lock_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_r && start_s |=> !heat_enable) else $error("heat restarted while locked");
    no_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_r.heat_lim == 8'h00 |-> !cut_now) else $error("cut with limit off");
    range_fix_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_r.range_alloy == RANGE_FIXED ##1 cfg_r.range_alloy == RANGE_FIXED |->
        range_sel == FIXED_RANGE_SEL) else $error("range not fixed");
    cal_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_r.cal_temp <= CAL_MAX) else $error("calibration temp out of range");
    diag_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(cfg_r.diag_en) |-> !diag_valid) else $error("diag reported while off");
    fault_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_code != 4'h0 && !cfg_r.swap_bytes |=> tx_word == {12'h000, $past(fault_code)})
        else $error("fault code missing in cyclic data");
    steady_led_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == LED_ON |=> alarm_led) else $error("led not steady");
    full_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_code == 4'h0 && meas_temp == TEMP_FULL |=> actual_dac == DAC_FULL)
        else $error("full scale wrong");
    imp_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        imp_cnt_r == 17'h0_0000 && meas_trigger |=> imp_cnt_r == $past(imp_load))
        else $error("impulse length wrong");
    cut_cover_c: cover property (@(posedge pclk) disable iff (!presetn) cut_now);
    fast_cover_c: cover property (@(posedge pclk) disable iff (!presetn) mode == LED_FAST);
    swap_cover_c: cover property (@(posedge pclk) disable iff (!presetn) wr_ok && sel_fmt);
endmodule : heatseal_param_supervisor
`default_nettype wire

//--- testbench/apb_master_model.sv
// APB master model standing in for the fieldbus master that configures the block.
`timescale 1ns/1ps
`default_nettype none
module apb_master_model
    import heatseal_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int hangs = 0; // Transfers that never saw pready.
    // The bus starts idle with nothing selected.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer: setup, access held until pready, then the lines are released.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) begin
            hangs++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so stale values cannot pass.
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    // Every range change is followed by a read of the interrupt status, whose data is returned.
    task automatic change_range(input logic [31:0] v, output logic e, output logic [31:0] s);
        logic de;
        xfer(1'b1, ADDR_RANGE, v, s, e);
        xfer(1'b0, ADDR_IRQ_STAT, 32'h0000_0000, s, de);
    endtask : change_range
endmodule : apb_master_model
`default_nettype wire

//--- testbench/heatseal_param_supervisor_tb_top.sv
// Self-checking testbench for the parameter supervisor.
`timescale 1ns/1ps
`default_nettype none
module heatseal_param_supervisor_tb_top
    import heatseal_pkg::*;
;
    localparam int HU = 10;
    localparam int FH = 4;
    localparam int SH = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, cal_o;
    logic [31:0] pwdata, prdata;
    logic start_req_pin = 1'b0;
    logic meas_trigger = 1'b0;
    logic [3:0] rot_r = 4'h0;
    logic [3:0] rot_c = 4'h0;
    logic [3:0] fault_code = 4'h0;
    logic [8:0] meas_temp = 9'h000;
    logic [8:0] set_point = 9'h0c8;
    logic [15:0] rx_word = 16'h1234;
    logic heat_enable, temp_ok, meas_impulse, alarm_led, diag_valid;
    logic [3:0] range_sel, coef, diag_code;
    logic [11:0] dac;
    logic [15:0] tx, rxo;
    int err_count = 0;
    int comparisons = 0;
    // The clock toggles every half period of 20 ns.
    initial begin
        forever #20 pclk = ~pclk;
    end
    apb_master_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    heatseal_param_supervisor #(.HEAT_UNIT(HU), .FAST_HALF(FH), .SLOW_HALF(SH)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_req_pin(start_req_pin), .rotary_range_pin(rot_r), .rotary_coef_pin(rot_c),
        .meas_temp(meas_temp), .set_point(set_point), .fault_code(fault_code),
        .meas_trigger(meas_trigger), .rx_word(rx_word), .heat_enable(heat_enable),
        .range_sel(range_sel), .element_temp_coefficient(coef), .cal_temp_out(cal_o),
        .temp_ok(temp_ok), .meas_impulse(meas_impulse), .actual_dac(dac),
        .alarm_led(alarm_led), .diag_valid(diag_valid), .diag_code(diag_code), .tx_word(tx),
        .rx_word_ordered(rxo), .irq(irq));
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        m.xfer(1'b1, a, d, r, e);
        chk(32'(e), 32'(xe));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        m.xfer(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
        chk(32'(e), 32'(xe));
    endtask : rd
    // Counts cycles a signal keeps one level, bounded.
    task automatic run(ref logic s, input logic v, output int n);
        n = 0;
        while (s === v && n < 50000) begin
            tick(1);
            n++;
        end
    endtask : run
    task automatic t_regs();
        logic e;
        logic [31:0] s;
        rd(ADDR_RANGE, 32'h0000_000a, 1'b0);
        rd(ADDR_CAL_TEMP, 32'h0000_0014, 1'b0);
        rd(ADDR_HEAT_LIM, 32'h0000_0000, 1'b0);
        rd(ADDR_DIAG_EN, 32'h0000_0001, 1'b0);
        rd(ADDR_IMP_LEN, 32'h0000_0011, 1'b0);
        rd(8'h3c, 32'h0000_0000, 1'b1);
        rot_r <= 4'h5;
        rot_c <= 4'h9;
        wr(ADDR_IRQ_MASK, 32'h0000_0007, 1'b0);
        m.change_range(32'h0000_0000, e, s);
        chk(32'(e), 32'h0000_0000);
        chk(s, 32'(1 << IRQ_RANGE));
        chk({range_sel, coef}, {FIXED_RANGE_SEL, FIXED_COEF_SEL});
        wr(ADDR_RANGE, 32'h0000_000a, 1'b0);
        tick(3);
        chk(32'(irq), 32'h0000_0001);
        chk({range_sel, coef}, 8'h59);
        rd(ADDR_IRQ_STAT, 32'(1 << IRQ_RANGE), 1'b0);
        tick(2);
        chk(32'(irq), 32'h0000_0000);
        wr(ADDR_RANGE, 32'h0000_0005, 1'b1);
        wr(ADDR_CAL_TEMP, 32'h0000_0029, 1'b1);
        wr(ADDR_CAL_TEMP, 32'h0000_0028, 1'b0);
        tick(2);
        chk(32'(cal_o), 32'h0000_0028);
        rd(ADDR_IRQ_STAT, 32'h0000_0000, 1'b0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_heat();
        int n;
        wr(ADDR_HEAT_LIM, 32'h0000_0033, 1'b1);
        wr(ADDR_HEAT_LIM, 32'h0000_0002, 1'b0);
        start_req_pin <= 1'b1;
        run(heat_enable, 1'b0, n);
        run(heat_enable, 1'b1, n);
        chk(32'(n == 2 * HU || n == 2 * HU + 1), 32'h0000_0001);
        tick(40);
        chk(32'(heat_enable), 32'h0000_0000);
        rd(ADDR_IRQ_STAT, 32'(1 << IRQ_CUTOFF), 1'b0);
        start_req_pin <= 1'b0;
        tick(5);
        start_req_pin <= 1'b1;
        tick(5);
        chk(32'(heat_enable), 32'h0000_0001);
        start_req_pin <= 1'b0;
        wr(ADDR_HEAT_LIM, 32'h0000_0000, 1'b0);
        start_req_pin <= 1'b1;
        tick(80);
        chk(32'(heat_enable), 32'h0000_0001);
        start_req_pin <= 1'b0;
        $display("test heat done");
    endtask : t_heat
    task automatic t_data();
        logic [8:0] tv[6] = '{9'd195, 9'd185, 9'd215, 9'd225, 9'd0, 9'd300};
        logic [12:0] xv[6] = '{13'h1a65, 13'h09dd, 13'h1b76, 13'h0bff, 13'h0000, 13'h0fff};
        int n;
        wr(ADDR_IMP_LEN, 32'h0000_0010, 1'b1);
        meas_trigger <= 1'b1;
        tick(1);
        meas_trigger <= 1'b0;
        run(meas_impulse, 1'b0, n);
        run(meas_impulse, 1'b1, n);
        chk(32'(n), 32'(17 * IMP_UNIT_CYC));
        wr(ADDR_OK_LOW, 32'h0000_0002, 1'b1);
        wr(ADDR_OK_HIGH, 32'h0000_0014, 1'b0);
        for (int i = 0; i < 6; i++) begin
            meas_temp <= tv[i];
            tick(4);
            chk({temp_ok, dac}, xv[i]);
        end
        rx_word <= 16'h1234;
        tick(4);
        chk(32'(tx), 32'h0000_012c);
        chk(32'(rxo), 32'h0000_1234);
        wr(ADDR_FORMAT, 32'h0000_0001, 1'b0);
        tick(4);
        chk({rxo, tx}, {16'h3412, 16'h2c01});
        wr(ADDR_FORMAT, 32'h0000_0000, 1'b0);
        $display("test data done");
    endtask : t_data
    task automatic t_fault();
        int n;
        wr(ADDR_DIAG_EN, 32'h0000_0000, 1'b0);
        for (int c = 1; c < 8; c++) begin
            fault_code <= 4'(c);
            tick(5);
            chk(32'(alarm_led), 32'h0000_0001);
            chk(32'(dac), 32'(c * 273));
            chk({diag_valid, tx[3:0]}, {1'b0, 4'(c)});
        end
        wr(ADDR_DIAG_EN, 32'h0000_0001, 1'b0);
        tick(4);
        chk({diag_valid, diag_code}, 5'h17);
        rd(ADDR_STATE, 32'h0007_0000, 1'b0);
        for (int c = 8; c < 13; c++) begin
            fault_code <= 4'(c);
            tick(2);
            run(alarm_led, alarm_led, n);
            run(alarm_led, alarm_led, n);
            chk(32'(n), 32'(c < 10 ? FH : SH));
        end
        fault_code <= 4'h0;
        $display("test fault done");
    endtask : t_fault
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count + m.hangs);
        if (err_count == 0 && m.hangs == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        tick(8);
        presetn <= 1'b1;
        t_regs();
        t_heat();
        t_data();
        t_fault();
        wrap_up();
    end
endmodule : heatseal_param_supervisor_tb_top
`default_nettype wire
